//--- src/eeq_status.sv
/*
 Status reporting top: event enable mask, event latch with summary bit,
 setting conflict checks and the error queue reader.
 Assumes command strobes are one-cycle pulses synchronous to mclk,
 decoded by the command parser outside this block.
*/
`timescale 1ns/10ps
module eeq_status #(
  parameter int QDEPTH = eeq_pkg::EEQ_Q_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Enable mask access
  input wire logic ese_wr,
  input wire logic [7:0] ese_wdata,
  input wire logic ese_rd,
  output logic [7:0] ese_rdata_q,
  output logic ese_rvalid_q,
  // Event latch and summary
  input wire logic [7:0] ev_set,
  input wire logic esr_rd,
  output logic [7:0] esr_rdata_q,
  output logic esr_rvalid_q,
  output logic esb_q,
  // Clear status
  input wire logic cls,
  // Parser, execution and device faults
  input wire logic cmd_err,
  input wire logic [3:0] cmd_kind,
  input wire logic exe_err,
  input wire logic [1:0] exe_kind,
  input wire logic dev_err,
  input wire logic mem_err,
  // Setting change requests
  input wire logic chk_valid,
  input wire logic chk_burst,
  input wire logic chk_seq,
  input wire logic chk_filt,
  input wire logic chk_sine,
  input wire logic chk_cont,
  input wire logic chk_trig,
  input wire logic chk_level,
  input wire logic chk_timing,
  // Present instrument settings
  input wire logic burst_on,
  input wire logic seq_on,
  input wire logic filt_on,
  input wire logic sine_on,
  input wire logic adv_single,
  input wire logic adv_auto,
  input wire logic [1:0] out_mode,
  input wire logic [15:0] ampl_mv,
  input wire logic [15:0] offs_mv,
  input wire logic [9:0] tsum_pct,
  // Query arrival
  input wire logic qry_new,
  input wire logic outbuf_busy,
  // Error queue read
  input wire logic err_rd,
  output logic [15:0] err_code_q,
  output logic err_rvalid_q,
  output logic err_pending_q
);

  // ----------------------------------------
  // Queue instance
  // ----------------------------------------

  eeq_q_if qi ();

  eeq_err_queue #(.DEPTH(QDEPTH)) u_queue (
    .mclk(mclk),
    .rst_n(rst_n),
    .q(qi.queue)
  );

  // ----------------------------------------
  // Setting conflict checks
  // ----------------------------------------

  logic [16:0] half_amp, abs_off;
  logic [17:0] lvl_sum, lvl_lim;
  logic lvl_over, time_over, mode_cf, filt_cf, adv_cf, conflict;

  // Half amplitude plus offset magnitude against the mode limit
  always_comb begin
    half_amp = {2'b00, ampl_mv[15:1]};
    abs_off = offs_mv[15] ? 17'(-{offs_mv[15], offs_mv})
                          : {1'b0, offs_mv};
    lvl_sum = {1'b0, half_amp} + {1'b0, abs_off};
    lvl_lim = (out_mode == eeq_pkg::EEQ_SYMMETRIC_OUTPUT_MODE)
              ? eeq_pkg::EEQ_LIM_SYM_MV
              : eeq_pkg::EEQ_LIM_PK_MV;
    lvl_over = chk_level && (lvl_sum > lvl_lim);
  end

  // Individual conflict cases
  assign time_over = chk_timing
                     && (tsum_pct > eeq_pkg::EEQ_PCT_FULL);
  assign mode_cf = (chk_burst && seq_on)
                   || (chk_seq && burst_on);
  assign filt_cf = (chk_filt && sine_on)
                   || (chk_sine && filt_on);
  assign adv_cf = (chk_cont && adv_single)
                  || (chk_trig && adv_auto);
  assign conflict = chk_valid
                    && (mode_cf || filt_cf || adv_cf
                        || time_over || lvl_over);

  // ----------------------------------------
  // Error source selection
  // ----------------------------------------

  logic exe_any, dev_any, qry_int;
  logic [15:0] exe_code;

  // Execution fault code from kind or a detected conflict
  always_comb begin
    exe_any = exe_err || conflict;
    case (exe_kind)
      eeq_pkg::EEQ_XK_RANGE: exe_code = eeq_pkg::EEQ_E_RANGE;
      eeq_pkg::EEQ_XK_ILLEG: exe_code = eeq_pkg::EEQ_E_ILLEG;
      eeq_pkg::EEQ_XK_CONFL: exe_code = eeq_pkg::EEQ_E_CONFL;
      default: exe_code = eeq_pkg::EEQ_E_EXEC;
    endcase
    if (conflict) exe_code = eeq_pkg::EEQ_E_CONFL;
  end

  assign dev_any = dev_err || mem_err;
  assign qry_int = qry_new && outbuf_busy;

  // One entry per cycle: parser, execution, device, query
  always_comb begin
    qi.push = 1'b1;
    qi.push_code = eeq_pkg::EEQ_E_NONE;
    if (cmd_err) begin
      qi.push_code = eeq_pkg::eeq_cmd_code(cmd_kind);
    end else if (exe_any) begin
      qi.push_code = exe_code;
    end else if (mem_err) begin
      qi.push_code = eeq_pkg::EEQ_E_MEM;
    end else if (dev_err) begin
      qi.push_code = eeq_pkg::EEQ_E_DEV;
    end else if (qry_int) begin
      qi.push_code = eeq_pkg::EEQ_E_QINT;
    end else begin
      qi.push = 1'b0;
    end
  end

  // Queue pop on read; clear-status empties it
  assign qi.pop = err_rd;
  assign qi.clr = cls;

  // ----------------------------------------
  // Enable mask
  // ----------------------------------------

  logic [7:0] ese_q, ese_d;

  // Mask write replaces every bit; zero clears all
  always_comb begin
    ese_d = ese_q;
    if (ese_wr) ese_d = ese_wdata;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) ese_q <= eeq_pkg::EEQ_ESE_RST;
    else ese_q <= ese_d;
  end

  // Mask query answers the binary-weighted bit sum
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ese_rdata_q <= 8'h00;
      ese_rvalid_q <= 1'b0;
    end else begin
      ese_rvalid_q <= ese_rd;
      if (ese_rd) ese_rdata_q <= ese_q;
    end
  end

  // ----------------------------------------
  // Event latch and summary bit
  // ----------------------------------------

  logic [7:0] esr_q, esr_d, ev_now;

  // Error events feed their latch positions
  always_comb begin
    ev_now = ev_set;
    ev_now[eeq_pkg::EEQ_EV_CME] = ev_set[eeq_pkg::EEQ_EV_CME]
                                  | cmd_err;
    ev_now[eeq_pkg::EEQ_EV_EXE] = ev_set[eeq_pkg::EEQ_EV_EXE]
                                  | exe_any;
    ev_now[eeq_pkg::EEQ_EV_DDE] = ev_set[eeq_pkg::EEQ_EV_DDE]
                                  | dev_any;
    ev_now[eeq_pkg::EEQ_EV_QYE] = ev_set[eeq_pkg::EEQ_EV_QYE]
                                  | qry_int;
  end

  // Read or clear-status empties the latch; new events win
  always_comb begin
    esr_d = esr_q;
    if (esr_rd || cls) esr_d = 8'h00;
    esr_d = esr_d | ev_now;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) esr_q <= eeq_pkg::EEQ_ESR_RST;
    else esr_q <= esr_d;
  end

  // Destructive latch read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      esr_rdata_q <= 8'h00;
      esr_rvalid_q <= 1'b0;
    end else begin
      esr_rvalid_q <= esr_rd;
      if (esr_rd) esr_rdata_q <= esr_q;
    end
  end

  // Summary bit tracks latch and mask as registered
  always_ff @(posedge mclk) begin
    if (!rst_n) esb_q <= 1'b0;
    else esb_q <= |(esr_d & ese_d);
  end

  // ----------------------------------------
  // Error queue read
  // ----------------------------------------

  // Oldest code, or zero when nothing is stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_code_q <= eeq_pkg::EEQ_E_NONE;
      err_rvalid_q <= 1'b0;
    end else begin
      err_rvalid_q <= err_rd;
      if (err_rd) err_code_q <= qi.head_code;
    end
  end

  // Queue holds entries
  always_ff @(posedge mclk) begin
    if (!rst_n) err_pending_q <= 1'b0;
    else err_pending_q <= !qi.empty;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ese_clear_a: assert property (ese_wr && ese_wdata == 8'h00
    |=> ese_q == 8'h00 && !esb_q)
    else $error("mask write of zero did not clear");
  ese_query_a: assert property (ese_rd && !ese_wr
    |=> ese_rvalid_q && ese_rdata_q == $past(ese_q))
    else $error("mask query returned wrong value");
  esb_sum_a: assert property (esb_q == |(esr_q & ese_q))
    else $error("summary bit disagrees with latch and mask");
  esr_clear_a: assert property ((esr_rd || cls) && ev_now == 8'h00
    |=> esr_q == 8'h00)
    else $error("event latch not cleared");
  cmd_push_a: assert property (cmd_err |-> qi.push
    && qi.push_code == eeq_pkg::eeq_cmd_code(cmd_kind))
    else $error("parser fault not queued");
  conflict_a: assert property (chk_valid && chk_burst && seq_on
    && !cmd_err |-> qi.push && qi.push_code == eeq_pkg::EEQ_E_CONFL
    ##1 esr_q[eeq_pkg::EEQ_EV_EXE])
    else $error("burst over sequence not flagged");
  qry_int_a: assert property (qry_int && !cmd_err && !exe_any
    && !dev_any |-> qi.push && qi.push_code == eeq_pkg::EEQ_E_QINT)
    else $error("interrupted query not queued");
  empty_read_a: assert property (err_rd && qi.empty
    |=> err_rvalid_q && err_code_q == eeq_pkg::EEQ_E_NONE)
    else $error("empty queue read not zero");

  // Read answers, range, memory and device fault codes, mask hold and the pending flag
  esr_read_a: assert property (esr_rd |=> esr_rvalid_q
    && esr_rdata_q == $past(esr_q))
    else $error("latch read returned wrong value");
  err_read_a: assert property (err_rd && !qi.empty
    |=> err_rvalid_q && err_code_q == $past(qi.head_code))
    else $error("queue read did not return head entry");
  exe_code_a: assert property (exe_err && !conflict && !cmd_err
    && exe_kind == eeq_pkg::EEQ_XK_RANGE
    |-> qi.push && qi.push_code == eeq_pkg::EEQ_E_RANGE)
    else $error("range fault code wrong");
  mem_code_a: assert property (mem_err && !cmd_err && !exe_any
    |-> qi.push && qi.push_code == eeq_pkg::EEQ_E_MEM)
    else $error("memory fault code wrong");
  dev_code_a: assert property (dev_err && !mem_err && !cmd_err
    && !exe_any |-> qi.push && qi.push_code == eeq_pkg::EEQ_E_DEV)
    else $error("device fault code wrong");
  ese_hold_a: assert property (!ese_wr |=> $stable(ese_q))
    else $error("mask changed without a write");
  pend_set_a: assert property (!qi.empty |=> err_pending_q)
    else $error("pending flag missed stored entry");
  pend_clr_a: assert property (qi.empty |=> !err_pending_q)
    else $error("pending flag set on empty queue");
endmodule : eeq_status

//--- pkg/eeq_pkg.sv
/*
 Constants for the status reporting block: event enable mask layout,
 error codes, queue sizing and setting limits.
 Assumes a single 100 MHz clock and a synchronous active-low reset.
*/
// Behaviour
// - Eight-bit mask gates latched events onto summary
// - Mask query returns weighted sum of bits
// - Mask write sets bits; zero clears all
// - Weights: OPC,RQC,QYE,DDE,EXE,CME,URQ,PON
// - Invalid command creates queued error entry
// - Queue returns oldest entry first, one per read
// - Empty queue read returns code zero
// - Beyond thirty errors mark overflow, drop rest
// - Power loss and clear-status empty queue
// - Entry is signed code plus short text; queue stores the 16-bit code only
// - Parser faults use command error codes
// - Unidentified separator fault may report generic
// - Execution faults use execution error codes
// - Burst versus sequence request is conflict
// - Filter versus built-in sine is conflict
// - Timing sum over full period conflicts
// - Level over output-mode limit conflicts
// - Wrong advance mode change conflicts
// - Device faults use codes -300, -311
// - Query over busy buffer reports -410
// - Event latch cleared by read, clear, power
package eeq_pkg;

  // Event latch and mask layout
  localparam int EEQ_EV_W = 8;
  localparam int EEQ_EV_OPC = 0;
  localparam int EEQ_EV_RQC = 1;
  localparam int EEQ_EV_QYE = 2;
  localparam int EEQ_EV_DDE = 3;
  localparam int EEQ_EV_EXE = 4;
  localparam int EEQ_EV_CME = 5;
  localparam int EEQ_EV_URQ = 6;
  localparam int EEQ_EV_PON = 7;
  localparam logic [7:0] EEQ_ESE_RST = 8'h00;
  localparam logic [7:0] EEQ_ESR_RST = 8'h00;

  // Error queue sizing
  localparam int EEQ_Q_DEPTH = 30;
  localparam int EEQ_MSG_MAX = 80;

  // Signed error codes, two's complement
  localparam logic [15:0] EEQ_E_NONE = 16'h0000;
  localparam logic [15:0] EEQ_E_CMD = 16'hff9c;
  localparam logic [15:0] EEQ_E_CHAR = 16'hff9b;
  localparam logic [15:0] EEQ_E_SYNTAX = 16'hff9a;
  localparam logic [15:0] EEQ_E_SEP = 16'hff99;
  localparam logic [15:0] EEQ_E_TYPE = 16'hff98;
  localparam logic [15:0] EEQ_E_EXTRA = 16'hff94;
  localparam logic [15:0] EEQ_E_MISS = 16'hff93;
  localparam logic [15:0] EEQ_E_NUM = 16'hff80;
  localparam logic [15:0] EEQ_E_SUFFIX = 16'hff7d;
  localparam logic [15:0] EEQ_E_CHDATA = 16'hff6c;
  localparam logic [15:0] EEQ_E_EXEC = 16'hff38;
  localparam logic [15:0] EEQ_E_CONFL = 16'hff23;
  localparam logic [15:0] EEQ_E_RANGE = 16'hff22;
  localparam logic [15:0] EEQ_E_ILLEG = 16'hff20;
  localparam logic [15:0] EEQ_E_DEV = 16'hfed4;
  localparam logic [15:0] EEQ_E_MEM = 16'hfec9;
  localparam logic [15:0] EEQ_E_OVF = 16'hfea2;
  localparam logic [15:0] EEQ_E_QINT = 16'hfe66;

  // Parser fault kinds
  localparam logic [3:0] EEQ_CK_GEN = 4'h0;
  localparam logic [3:0] EEQ_CK_CHAR = 4'h1;
  localparam logic [3:0] EEQ_CK_SYNTAX = 4'h2;
  localparam logic [3:0] EEQ_CK_SEP = 4'h3;
  localparam logic [3:0] EEQ_CK_TYPE = 4'h4;
  localparam logic [3:0] EEQ_CK_EXTRA = 4'h5;
  localparam logic [3:0] EEQ_CK_MISS = 4'h6;
  localparam logic [3:0] EEQ_CK_NUM = 4'h7;
  localparam logic [3:0] EEQ_CK_SUFFIX = 4'h8;
  localparam logic [3:0] EEQ_CK_CHDATA = 4'h9;
  localparam logic [3:0] EEQ_CK_SEPGEN = 4'ha;

  // Execution fault kinds
  localparam logic [1:0] EEQ_XK_GEN = 2'h0;
  localparam logic [1:0] EEQ_XK_RANGE = 2'h1;
  localparam logic [1:0] EEQ_XK_ILLEG = 2'h2;
  localparam logic [1:0] EEQ_XK_CONFL = 2'h3;

  // Output modes and level limits in millivolts
  localparam logic [1:0] EEQ_SYMMETRIC_OUTPUT_MODE = 2'h0;
  localparam logic [1:0] EEQ_POSITIVE_OUTPUT_MODE = 2'h1;
  localparam logic [1:0] EEQ_NEGATIVE_OUTPUT_MODE = 2'h2;
  localparam logic [17:0] EEQ_LIM_SYM_MV = 18'h055f0;
  localparam logic [17:0] EEQ_LIM_PK_MV = 18'h04e20;
  localparam logic [9:0] EEQ_PCT_FULL = 10'h064;

  // Parser fault kind to error code
  function automatic logic [15:0] eeq_cmd_code(input logic [3:0] k);
    logic [15:0] c;
    c = EEQ_E_CMD;
    case (k)
      EEQ_CK_CHAR: c = EEQ_E_CHAR;
      EEQ_CK_SYNTAX: c = EEQ_E_SYNTAX;
      EEQ_CK_SEP: c = EEQ_E_SEP;
      EEQ_CK_TYPE: c = EEQ_E_TYPE;
      EEQ_CK_EXTRA: c = EEQ_E_EXTRA;
      EEQ_CK_MISS: c = EEQ_E_MISS;
      EEQ_CK_NUM: c = EEQ_E_NUM;
      EEQ_CK_SUFFIX: c = EEQ_E_SUFFIX;
      EEQ_CK_CHDATA: c = EEQ_E_CHDATA;
      default: c = EEQ_E_CMD;
    endcase
    return c;
  endfunction : eeq_cmd_code

endpackage : eeq_pkg

//--- pkg/eeq_q_if.sv
/*
 Link between the status block and its error queue.
 Assumes both ends share mclk.
*/
`timescale 1ns/10ps
interface eeq_q_if;
  logic push;
  logic [15:0] push_code;
  logic pop;
  logic clr;
  logic [15:0] head_code;
  logic empty;
  logic full;
  modport owner (output push, push_code, pop, clr,
                 input head_code, empty, full);
  modport queue (input push, push_code, pop, clr,
                 output head_code, empty, full);
endinterface : eeq_q_if

//--- src/eeq_err_queue.sv
/*
 Error queue: first-in first-out store of signed error codes with
 overflow marking. Assumes one push and one pop at most per cycle.
*/
`timescale 1ns/10ps
module eeq_err_queue #(
  parameter int DEPTH = eeq_pkg::EEQ_Q_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Queue port
  eeq_q_if.queue q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [15:0] mem_q [DEPTH];
  logic [AW-1:0] rd_q, wr_q;
  logic [AW:0] cnt_q;
  logic ovf_q, do_pop, accept, replace;

  // Circular pointer steps
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction : nxt
  function automatic logic [AW-1:0] prv(input logic [AW-1:0] p);
    return (p == '0) ? LAST : p - 1'b1;
  endfunction : prv

  // Status and handshake terms
  assign q.empty = (cnt_q == '0);
  assign q.full = (cnt_q == (AW+1)'(DEPTH));
  assign do_pop = q.pop && !q.empty;
  assign accept = q.push && (!q.full || do_pop);
  assign replace = q.push && q.full && !do_pop && !ovf_q;
  assign q.head_code = q.empty ? eeq_pkg::EEQ_E_NONE : mem_q[rd_q];

  // Pointers, fill count and overflow mark
  always_ff @(posedge mclk) begin
    if (!rst_n || q.clr) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (do_pop) rd_q <= nxt(rd_q);
      if (accept) wr_q <= nxt(wr_q);
      if (accept && !do_pop) cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !accept) cnt_q <= cnt_q - 1'b1;
      if (do_pop) ovf_q <= 1'b0;
      else if (replace) ovf_q <= 1'b1;
    end
  end

  // Entry storage; newest slot turns into the overflow marker
  always_ff @(posedge mclk) begin
    if (accept) mem_q[wr_q] <= q.push_code;
    else if (replace) mem_q[prv(wr_q)] <= eeq_pkg::EEQ_E_OVF;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ovf_mark_a: assert property (replace && !q.clr |=>
    mem_q[prv(wr_q)] == eeq_pkg::EEQ_E_OVF && q.full)
    else $error("overflow marker not stored");
  ovf_drop_a: assert property (ovf_q && q.push && !do_pop
    && !q.clr |=> $stable(wr_q) && q.full)
    else $error("error stored while overflowed");
  clr_empty_a: assert property (q.clr |=> q.empty)
    else $error("queue not emptied by clear");
  fifo_head_a: assert property (q.push && q.empty && !q.clr
    |=> q.head_code == $past(q.push_code))
    else $error("head is not oldest entry");
endmodule : eeq_err_queue

//--- test/eeq_ctrl_model.sv
/*
 Remote controller model: issues command and query strobes to the
 status block. Assumes the block takes each strobe on a rising mclk edge.
*/
`timescale 1ns/10ps
module eeq_ctrl_model (
  // Clock
  input wire logic mclk,
  // Strobes and their operand
  output logic [10:0] strb,
  output logic [7:0] wdata,
  output logic [7:0] ev_set
);
  // ----------------------------------------
  // Request driver
  // ----------------------------------------
  // Idle at time zero
  initial begin
    strb = 11'h000;
    wdata = 8'h00;
    ev_set = 8'h00;
  end

  // Let one edge pass first so this request never lands in the time
  // step of the previous release; hold over the taking edge, release,
  // and return while the one-cycle answer still stands
  task automatic send(input int idx, input logic [7:0] d);
    @(posedge mclk);
    #1;
    wdata = d;
    if (idx == 11) begin
      ev_set = d;
    end else begin
      strb[idx] = 1'b1;
    end
    @(posedge mclk);
    #1;
    strb = 11'h000;
    ev_set = 8'h00;
    wdata = ~d; // Released operand does not keep its old value
  endtask : send
endmodule : eeq_ctrl_model

//--- test/tb_top.sv
/*
 Self-checking bench for the status block: mask, event latch, summary,
 error queue order, codes, conflicts, overflow and clearing.
 Assumes the controller model in eeq_ctrl_model and one 100 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
  logic mclk, rst_n, busy, ese_rvalid_q, esr_rvalid_q, esb_q;
  logic err_rvalid_q, err_pending_q;
  logic [10:0] strb;
  logic [7:0] wd, ev_set, chk, ese_rdata_q, esr_rdata_q;
  logic [5:0] st;
  logic [1:0] out_mode;
  logic [15:0] offs, err_code_q;
  logic [9:0] tsum;
  logic [15:0] ctab [11];
  logic [15:0] xtab [4];
  logic [5:0] stab [6];
  logic [15:0] expq [$];
  int mismatches, checks;

  // ----------------------------------------
  // Design and controller
  // ----------------------------------------
  eeq_status i_eeq_status (
    .mclk(mclk), .rst_n(rst_n), .ese_wr(strb[0]), .ese_wdata(wd),
    .ese_rd(strb[1]), .ese_rdata_q(ese_rdata_q),
    .ese_rvalid_q(ese_rvalid_q), .ev_set(ev_set), .esr_rd(strb[2]),
    .esr_rdata_q(esr_rdata_q), .esr_rvalid_q(esr_rvalid_q),
    .esb_q(esb_q), .cls(strb[4]), .cmd_err(strb[5]),
    .cmd_kind(wd[3:0]), .exe_err(strb[6]), .exe_kind(wd[1:0]),
    .dev_err(strb[7]), .mem_err(strb[8]), .chk_valid(strb[9]),
    .chk_burst(chk[0]), .chk_seq(chk[1]), .chk_filt(chk[2]),
    .chk_sine(chk[3]), .chk_cont(chk[4]), .chk_trig(chk[5]),
    .chk_level(chk[6]), .chk_timing(chk[7]), .burst_on(st[0]),
    .seq_on(st[1]), .filt_on(st[2]), .sine_on(st[3]),
    .adv_single(st[4]), .adv_auto(st[5]), .out_mode(out_mode),
    .ampl_mv(16'h4e20), .offs_mv(offs), .tsum_pct(tsum),
    .qry_new(strb[10]), .outbuf_busy(busy), .err_rd(strb[3]),
    .err_code_q(err_code_q), .err_rvalid_q(err_rvalid_q),
    .err_pending_q(err_pending_q)
  );
  eeq_ctrl_model i_eeq_ctrl_model (
    .mclk(mclk), .strb(strb), .wdata(wd), .ev_set(ev_set)
  );

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic snd(input int idx, input logic [7:0] d);
    i_eeq_ctrl_model.send(idx, d);
  endtask : snd

  // Answer pulse is already up when the request task returns
  task automatic rd_err(input logic [15:0] exp);
    snd(3, 8'h00);
    cmp_flag(err_rvalid_q, 1'b1);
    cmp_val(err_code_q, exp);
  endtask : rd_err

  task automatic push_cmd(input int k);
    snd(5, 8'(k));
    expq.push_back(ctab[k]);
  endtask : push_cmd

  // One setting-change request and whether it must conflict
  task automatic req(input logic [7:0] c, input logic [5:0] s,
                     input logic [1:0] m, input logic [15:0] o,
                     input logic [9:0] t, input logic hit);
    chk = c;
    st = s;
    out_mode = m;
    offs = o;
    tsum = t;
    snd(9, 8'h00);
    if (hit) begin
      expq.push_back(eeq_pkg::EEQ_E_CONFL);
    end
  endtask : req

  task automatic close_out;
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Watchdog on the whole run
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] b;
    rst_n = 1'b0;
    busy = 1'b0;
    chk = 8'h00;
    st = 6'h00;
    out_mode = 2'h0;
    offs = 16'h0000;
    tsum = 10'h000;
    mismatches = 0;
    checks = 0;
    ctab = '{eeq_pkg::EEQ_E_CMD, eeq_pkg::EEQ_E_CHAR,
             eeq_pkg::EEQ_E_SYNTAX, eeq_pkg::EEQ_E_SEP,
             eeq_pkg::EEQ_E_TYPE, eeq_pkg::EEQ_E_EXTRA,
             eeq_pkg::EEQ_E_MISS, eeq_pkg::EEQ_E_NUM,
             eeq_pkg::EEQ_E_SUFFIX, eeq_pkg::EEQ_E_CHDATA,
             eeq_pkg::EEQ_E_CMD};
    xtab = '{eeq_pkg::EEQ_E_EXEC, eeq_pkg::EEQ_E_RANGE,
             eeq_pkg::EEQ_E_ILLEG, eeq_pkg::EEQ_E_CONFL};
    stab = '{6'h02, 6'h01, 6'h08, 6'h04, 6'h10, 6'h20};
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd_err(eeq_pkg::EEQ_E_NONE);
    // Each weight: masked event stays off the summary, enabled one shows
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      snd(0, 8'hff ^ b);
      snd(11, b);
      cmp_flag(esb_q, 1'b0);
      snd(0, b);
      cmp_flag(esb_q, 1'b1);
      snd(1, 8'h00);
      cmp_flag(ese_rvalid_q, 1'b1);
      cmp_val({8'h00, ese_rdata_q}, {8'h00, b});
      snd(2, 8'h00);
      cmp_flag(esr_rvalid_q, 1'b1);
      cmp_val({8'h00, esr_rdata_q}, {8'h00, b});
      cmp_flag(esb_q, 1'b0);
      snd(2, 8'h00);
      cmp_val({8'h00, esr_rdata_q}, 16'h0000);
    end
    snd(0, 8'h00);
    snd(1, 8'h00);
    cmp_val({8'h00, ese_rdata_q}, 16'h0000);
    // Every fault source, then the conflict table, drained in order
    for (int k = 0; k < 11; k++) push_cmd(k);
    for (int k = 0; k < 4; k++) begin
      snd(6, 8'(k));
      expq.push_back(xtab[k]);
    end
    snd(7, 8'h00);
    expq.push_back(eeq_pkg::EEQ_E_DEV);
    snd(8, 8'h00);
    expq.push_back(eeq_pkg::EEQ_E_MEM);
    busy = 1'b1;
    snd(10, 8'h00);
    expq.push_back(eeq_pkg::EEQ_E_QINT);
    busy = 1'b0;
    for (int i = 0; i < 6; i++) begin
      req(8'h01 << i, ~stab[i], 2'h0, 16'h0000, 10'h000, 1'b0);
      req(8'h01 << i, stab[i], 2'h0, 16'h0000, 10'h000, 1'b1);
    end
    req(8'h40, 6'h00, 2'h0, 16'h2ee0, 10'h000, 1'b0);
    req(8'h40, 6'h00, 2'h0, 16'h2ee1, 10'h000, 1'b1);
    req(8'h40, 6'h00, 2'h1, 16'hd8f0, 10'h000, 1'b0);
    req(8'h40, 6'h00, 2'h2, 16'hd8ef, 10'h000, 1'b1);
    req(8'h80, 6'h00, 2'h0, 16'h0000, 10'h064, 1'b0);
    req(8'h80, 6'h00, 2'h0, 16'h0000, 10'h065, 1'b1);
    cmp_flag(err_pending_q, 1'b1);
    while (expq.size() > 0) rd_err(expq.pop_front());
    rd_err(eeq_pkg::EEQ_E_NONE);
    cmp_flag(err_pending_q, 1'b0);
    // Overflow: twenty-nine kept, thirtieth marked, later ones dropped
    for (int k = 0; k < 30; k++) push_cmd(k % 10);
    cmp_flag(err_pending_q, 1'b1);
    snd(5, 8'h02);
    snd(5, 8'h01);
    for (int k = 0; k < 29; k++) rd_err(expq.pop_front());
    rd_err(eeq_pkg::EEQ_E_OVF);
    rd_err(eeq_pkg::EEQ_E_NONE);
    expq.delete();
    // Clear-status and power loss both empty the queue
    snd(5, 8'h02);
    snd(4, 8'h00);
    rd_err(eeq_pkg::EEQ_E_NONE);
    snd(5, 8'h02);
    snd(0, 8'h10);
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd_err(eeq_pkg::EEQ_E_NONE);
    cmp_flag(err_pending_q, 1'b0);
    snd(1, 8'h00);
    cmp_val({8'h00, ese_rdata_q}, 16'h0000);
    close_out();
  end
endmodule : tb_top
